// File: design/cpu_control_inputs_min_mode_strobes.sv
// Processor control inputs, bus state sequencer and minimum-mode strobes
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// [RL1] Maskable request is a synchronised level, sampled at instruction boundaries.
// [RL2] Maskable request is ignored while the enable flag is clear.
// [RL3] Wait-for-test proceeds when test is asserted, else idles and rechecks.
// [RL4] Test input is synchronised before use.
// [RL5] A low-to-high edge on the nonmaskable input starts its interrupt.
// [RL6] The nonmaskable interrupt has no mask; the enable flag never blocks it.
// [RL7] The nonmaskable input is synchronised before edge detection.
// [RL8] Reset held at least four cycles; while high all activity is abandoned.
// [RL9] Execution restarts from the reset state when reset returns low.
// [RL10] Mode input high selects minimum mode strobes instead of status outputs.
// [RL11] Memory/IO line is inverted status bit two: high for I/O.
// [RL12] Memory/IO valid from the final state before a cycle until its end.
// [RL13] Memory/IO floats at logic one during hold grant.
// [RL14] Write strobe low in second, third and wait states of writes.
// [RL15] Write strobe floats at logic one during hold grant.
// [RL16] Acknowledge strobe low in second, third and wait states of ack cycles.
// [RL17] Wait states are inserted while ready is low.
// [RL18] Hold grant rises after a final or idle state; drops after request drops.
// [RL19] Cycles run first to fourth state in order, waits after the third.
module cpu_control_inputs_min_mode_strobes (
    // Clock and system reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Asynchronous processor pins
    input wire logic cpu_reset_in,
    input wire logic mode_select_in,
    input wire logic maskable_irq_in,
    input wire logic nmi_in,
    input wire logic test_in_n,
    input wire logic ready_in,
    input wire logic hold_req_in,
    // Execution unit requests
    input wire logic req_valid,
    input wire cpu_ctrl_pkg::bus_req_t req,
    input wire logic boundary,
    input wire logic int_enable,
    input wire logic wait_test,
    // Execution unit answers
    output logic req_taken,
    output logic cycle_done,
    output logic restart,
    output cpu_ctrl_pkg::irq_events_t events,
    // Bus control pins
    output cpu_ctrl_pkg::min_strobes_t min_pins,
    output cpu_ctrl_pkg::max_status_t max_pins,
    output logic hold_grant_out
);

    // ------------------------------------------------------------
    // Reset and input synchronisation
    // ------------------------------------------------------------

    logic [1:0] rst_pipe;
    logic rst_n;
    logic [6:0] pins_s;
    logic abandon;
    logic mode_s;
    logic irq_s;
    logic nmi_s;
    logic test_s_n;
    logic ready_s;
    logic hold_s;

    // Reset asserts at once and releases through two flops
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            rst_pipe <= 2'h0;
        else
            rst_pipe <= {rst_pipe[0], 1'h1};
    end
    assign rst_n = rst_pipe[1];

    // All processor pins pass two flops before use
    input_sync #(.WIDTH(7)) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .raw({cpu_reset_in, mode_select_in, maskable_irq_in, nmi_in,
              test_in_n, ready_in, hold_req_in}),
        .synced(pins_s)
    ); // RL4 RL7

    // Named copies of the synchronised pins
    assign {abandon, mode_s, irq_s, nmi_s, test_s_n, ready_s, hold_s} = pins_s;

    // ------------------------------------------------------------
    // Interrupts and wait-for-test
    // ------------------------------------------------------------

    irq_ctl u_irq (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .abandon(abandon),
        .irq_level(irq_s),
        .nmi_level(nmi_s),
        .test_level_n(test_s_n),
        .boundary(boundary),
        .int_enable(int_enable),
        .wait_test(wait_test),
        .events(events)
    );

    // ------------------------------------------------------------
    // Processor reset handling
    // ------------------------------------------------------------

    logic [2:0] rst_cnt;
    logic abandon_prev;

    // Restart only after a reset pulse of the least length
    wire rst_long = (rst_cnt == cpu_ctrl_pkg::RESET_COUNT_MAX);
    wire next_restart = abandon_prev & ~abandon & rst_long; // RL8 RL9

    // Count reset cycles, saturating at the least length
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_cnt <= 3'h0;
            abandon_prev <= 1'h0;
            restart <= 1'h0;
        end
        else
        begin
            rst_cnt <= abandon ? (rst_long ? rst_cnt : rst_cnt + 3'h1) : 3'h0;
            abandon_prev <= abandon;
            restart <= next_restart;
        end
    end

    // ------------------------------------------------------------
    // Bus state sequencer
    // ------------------------------------------------------------

    cpu_ctrl_pkg::bus_state_t state;
    cpu_ctrl_pkg::bus_state_t next_state;
    cpu_ctrl_pkg::cycle_kind_t cur_kind;
    logic loaded;
    logic io_level;

    // A request is taken from idle, or while the current cycle ends
    wire in_end = (state == cpu_ctrl_pkg::ST_T3) | (state == cpu_ctrl_pkg::ST_WAIT);
    wire take_idle = (state == cpu_ctrl_pkg::ST_IDLE) & req_valid & ~hold_s;
    wire take_end = in_end & ready_s & req_valid & ~hold_s;
    wire take = ~abandon & (take_idle | take_end);

    // Next state; wait states follow the third state while not ready
    always_comb
    begin
        next_state = cpu_ctrl_pkg::ST_IDLE;
        if (abandon)
            next_state = cpu_ctrl_pkg::ST_IDLE; // RL8
        else
        begin
            unique case (state)
                cpu_ctrl_pkg::ST_IDLE:
                    if (hold_s)
                        next_state = cpu_ctrl_pkg::ST_HOLD; // RL18
                    else if (req_valid)
                        next_state = cpu_ctrl_pkg::ST_PREP;
                cpu_ctrl_pkg::ST_PREP:
                    next_state = cpu_ctrl_pkg::ST_T1; // RL19
                cpu_ctrl_pkg::ST_T1:
                    next_state = cpu_ctrl_pkg::ST_T2;
                cpu_ctrl_pkg::ST_T2:
                    next_state = cpu_ctrl_pkg::ST_T3;
                cpu_ctrl_pkg::ST_T3, cpu_ctrl_pkg::ST_WAIT:
                    next_state = ready_s ? cpu_ctrl_pkg::ST_FINAL
                                         : cpu_ctrl_pkg::ST_WAIT; // RL17
                cpu_ctrl_pkg::ST_FINAL:
                    if (loaded)
                        next_state = cpu_ctrl_pkg::ST_T1;
                    else if (hold_s)
                        next_state = cpu_ctrl_pkg::ST_HOLD; // RL18
                cpu_ctrl_pkg::ST_HOLD:
                    if (hold_s)
                        next_state = cpu_ctrl_pkg::ST_HOLD;
                default:
                    next_state = cpu_ctrl_pkg::ST_IDLE;
            endcase
        end
    end

    // State, taken request and preloaded flag
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= cpu_ctrl_pkg::ST_IDLE;
            cur_kind <= cpu_ctrl_pkg::CYC_PASSIVE;
            loaded <= 1'h0;
        end
        else
        begin
            state <= next_state;
            cur_kind <= take ? req.kind : cur_kind;
            loaded <= ~abandon & (take_end | (loaded & (state != cpu_ctrl_pkg::ST_FINAL)));
        end
    end

    // ------------------------------------------------------------
    // Strobes, status and hold grant
    // ------------------------------------------------------------

    cpu_ctrl_pkg::min_strobes_t next_min;
    cpu_ctrl_pkg::max_status_t next_max;

    // Strobe window and cycle kind decode
    wire next_strobe = (next_state == cpu_ctrl_pkg::ST_T2) |
                       (next_state == cpu_ctrl_pkg::ST_T3) |
                       (next_state == cpu_ctrl_pkg::ST_WAIT);
    wire is_write = (cur_kind == cpu_ctrl_pkg::CYC_IO_WRITE) |
                    (cur_kind == cpu_ctrl_pkg::CYC_MEM_WRITE);
    wire is_ack = (cur_kind == cpu_ctrl_pkg::CYC_INT_ACK);
    wire next_float = (next_state == cpu_ctrl_pkg::ST_HOLD);
    wire next_drive_min = mode_s & ~next_float; // RL10
    wire next_io_level = take ? ~req.kind[cpu_ctrl_pkg::STATUS_BIT2] : io_level; // RL11 RL12
    wire next_done = ~abandon & in_end & ready_s;

    // Pin values; floated lines sit at logic one
    assign next_min.io_mem = next_float | next_io_level; // RL13
    assign next_min.io_mem_oe = next_drive_min;
    assign next_min.write_n = next_float | ~(next_strobe & is_write); // RL14 RL15
    assign next_min.write_oe = next_drive_min;
    assign next_min.irq_ack_strobe_n = next_float | ~(next_strobe & is_ack); // RL16
    assign next_min.irq_ack_oe = next_drive_min;

    // Status code valid from the taking edge until the third state
    assign next_max.max_status = take ? req.kind :
        (next_state == cpu_ctrl_pkg::ST_T3 || abandon) ? cpu_ctrl_pkg::CYC_PASSIVE
                                                      : max_pins.max_status;
    assign next_max.max_status_oe = ~mode_s & ~next_float; // RL10

    // Registered pins and answers
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            io_level <= cpu_ctrl_pkg::IO_LEVEL_RESET;
            min_pins <= '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0};
            max_pins <= '{cpu_ctrl_pkg::CYC_PASSIVE, 1'h0};
            hold_grant_out <= 1'h0;
            req_taken <= 1'h0;
            cycle_done <= 1'h0;
        end
        else
        begin
            io_level <= next_io_level;
            min_pins <= next_min;
            max_pins <= next_max;
            hold_grant_out <= next_float; // RL18
            req_taken <= take;
            cycle_done <= next_done;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    irq_mask_a: assert property ( // RL2
        events.irq_take |-> $past(int_enable) && $past(boundary) && $past(irq_s))
        else $error("Maskable interrupt taken while disabled");

    nmi_unmasked_a: assert property ( // RL6
        ((u_irq.nmi_pending || $rose(nmi_s)) && boundary && !abandon && !int_enable)
        |=> events.nmi_take)
        else $error("Nonmaskable edge not taken");

    test_wait_a: assert property ( // RL3
        (wait_test && test_s_n && !abandon) |=> events.test_idle && !events.test_go)
        else $error("Wait for test did not idle");

    test_sync_a: assert property ( // RL4
        events.test_go |-> $past(test_in_n, 3) == 1'h0)
        else $error("Test used before synchronisation");

    write_strobe_a: assert property ( // RL14
        (state inside {cpu_ctrl_pkg::ST_T2, cpu_ctrl_pkg::ST_T3, cpu_ctrl_pkg::ST_WAIT}
         && is_write) |-> !min_pins.write_n && min_pins.irq_ack_strobe_n)
        else $error("Write strobe missing");

    ack_strobe_a: assert property ( // RL16
        (state == cpu_ctrl_pkg::ST_T2 && is_ack && !abandon) |=>
        !min_pins.irq_ack_strobe_n && min_pins.write_n)
        else $error("Acknowledge strobe missing");

    io_valid_a: assert property ( // RL11
        (state == cpu_ctrl_pkg::ST_T1) |-> min_pins.io_mem == ~cur_kind[cpu_ctrl_pkg::STATUS_BIT2])
        else $error("Memory/IO level wrong");

    io_stable_a: assert property ( // RL12
        (state inside {cpu_ctrl_pkg::ST_T2, cpu_ctrl_pkg::ST_T3, cpu_ctrl_pkg::ST_WAIT})
        |-> $stable(min_pins.io_mem))
        else $error("Memory/IO changed inside a cycle");

    hold_float_a: assert property ( // RL13 RL15
        hold_grant_out |-> !min_pins.io_mem_oe && !min_pins.write_oe
        && min_pins.io_mem && min_pins.write_n)
        else $error("Strobes driven during hold");

    wait_ready_a: assert property ( // RL17
        (in_end && !ready_s && !abandon) |=> state == cpu_ctrl_pkg::ST_WAIT && !cycle_done)
        else $error("Wait state not inserted");

    seq_order_a: assert property ( // RL19
        (state == cpu_ctrl_pkg::ST_T1 && !abandon ##1 !abandon)
        |-> state == cpu_ctrl_pkg::ST_T2 ##1 state == cpu_ctrl_pkg::ST_T3)
        else $error("Bus states out of order");

    reset_abandon_a: assert property ( // RL8
        abandon |=> state == cpu_ctrl_pkg::ST_IDLE && !hold_grant_out && min_pins.write_n)
        else $error("Reset did not abandon activity");

    restart_len_a: assert property ( // RL9
        restart |-> $past(rst_cnt) == cpu_ctrl_pkg::RESET_COUNT_MAX && !$past(abandon))
        else $error("Restart without full reset");

    mode_pins_a: assert property ( // RL10
        !mode_s |=> !min_pins.io_mem_oe && !min_pins.write_oe && !min_pins.irq_ack_oe)
        else $error("Minimum strobes driven in maximum mode");

    hold_grant_a: assert property ( // RL18
        $rose(hold_grant_out) |-> $past(state) inside {cpu_ctrl_pkg::ST_IDLE,
        cpu_ctrl_pkg::ST_FINAL} && $past(hold_s))
        else $error("Hold grant at wrong state");

    write_wait_c: cover property (
        is_write && state == cpu_ctrl_pkg::ST_WAIT ##1 state == cpu_ctrl_pkg::ST_FINAL);
    ack_cycle_c: cover property (is_ack && state == cpu_ctrl_pkg::ST_T3);
    hold_c: cover property ($fell(hold_grant_out));
    nmi_c: cover property (events.nmi_take);

endmodule

`default_nettype wire

// File: pkg/cpu_ctrl_pkg.sv
// Shared types and constants for the processor control and strobe block
package cpu_ctrl_pkg;

    // Depth of every input synchroniser
    localparam int SYNC_STAGES = 2;
    // Least number of cycles the processor reset pin must stay high
    localparam int RESET_MIN_CYCLES = 4;
    localparam logic [2:0] RESET_COUNT_MAX = 3'h4;
    // Bit of the status code that the memory/IO line inverts
    localparam int STATUS_BIT2 = 2;
    // Reset value of the registered memory/IO level
    localparam logic IO_LEVEL_RESET = 1'h0;

    // Bus states, one-hot
    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_PREP  = 8'h02,
        ST_T1    = 8'h04,
        ST_T2    = 8'h08,
        ST_T3    = 8'h10,
        ST_WAIT  = 8'h20,
        ST_FINAL = 8'h40,
        ST_HOLD  = 8'h80
    } bus_state_t;

    // Cycle kinds, coded as the three maximum-mode status bits
    typedef enum logic [2:0] {
        CYC_INT_ACK   = 3'h0,
        CYC_IO_READ   = 3'h1,
        CYC_IO_WRITE  = 3'h2,
        CYC_HALT      = 3'h3,
        CYC_CODE      = 3'h4,
        CYC_MEM_READ  = 3'h5,
        CYC_MEM_WRITE = 3'h6,
        CYC_PASSIVE   = 3'h7
    } cycle_kind_t;

    // Bus cycle request from the execution unit
    typedef struct packed {
        cycle_kind_t kind;
    } bus_req_t;

    // Minimum-mode strobe pins, value and output enable
    typedef struct packed {
        logic io_mem;
        logic io_mem_oe;
        logic write_n;
        logic write_oe;
        logic irq_ack_strobe_n;
        logic irq_ack_oe;
    } min_strobes_t;

    // Maximum-mode status pins
    typedef struct packed {
        cycle_kind_t max_status;
        logic max_status_oe;
    } max_status_t;

    // Interrupt and test events toward the execution unit
    typedef struct packed {
        logic irq_take;
        logic nmi_take;
        logic test_go;
        logic test_idle;
    } irq_events_t;

endpackage

// File: design/input_sync.sv
// Bank of two-flop synchronisers for asynchronous pins
`timescale 1ns/100ps
`default_nettype none

module input_sync #(
    parameter int WIDTH = 7
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Raw pins and synchronised copies
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] synced
);

    // One synchroniser per pin
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic [cpu_ctrl_pkg::SYNC_STAGES-1:0] stage;
            always_ff @(posedge sys_clk or negedge rst_n)
            begin
                if (!rst_n)
                    stage <= '0;
                else
                    stage <= {stage[cpu_ctrl_pkg::SYNC_STAGES-2:0], raw[i]};
            end
            assign synced[i] = stage[cpu_ctrl_pkg::SYNC_STAGES-1];
        end
    endgenerate

endmodule

`default_nettype wire

// File: design/irq_ctl.sv
// Maskable and nonmaskable interrupt decision and wait-for-test logic
`timescale 1ns/100ps
`default_nettype none

module irq_ctl (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic abandon,
    // Synchronised pins
    input wire logic irq_level,
    input wire logic nmi_level,
    input wire logic test_level_n,
    // Execution unit
    input wire logic boundary,
    input wire logic int_enable,
    input wire logic wait_test,
    output cpu_ctrl_pkg::irq_events_t events
);

    logic nmi_prev;
    logic nmi_pending;

    // Edge and decision terms
    wire nmi_rise = nmi_level & ~nmi_prev;
    wire take_nmi = boundary & (nmi_pending | nmi_rise);
    wire take_irq = boundary & irq_level & int_enable & ~take_nmi;
    wire test_ok = wait_test & ~test_level_n;
    wire test_wait = wait_test & test_level_n;

    // Edge detector history, high at reset; the synchronised line resets low, so a line held high still gives an edge
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            nmi_prev <= 1'h1;
        else
            nmi_prev <= nmi_level;
    end

    // Pending edge; a new edge in the taking cycle is that same event
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            nmi_pending <= 1'h0;
        else if (abandon)
            nmi_pending <= 1'h0;
        else
            nmi_pending <= (nmi_pending | nmi_rise) & ~take_nmi; // RL5
    end

    // Registered events; the enable flag never gates the edge path
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            events <= '0;
        else if (abandon)
            events <= '0;
        else
            events <= '{take_irq, take_nmi, test_ok, test_wait}; // RL1 RL2 RL3 RL6
    end

endmodule

`default_nettype wire

// File: test/bus_partner_model.sv
// Memory and I/O partner: answers ready promptly or slowly and raises hold on command
`timescale 1ns/100ps
`default_nettype none

module bus_partner_model (
    // Clock and bus view
    input wire logic sys_clk,
    input wire logic req_taken,
    // Commands from the bench
    input wire logic slow,
    input wire logic hold_on,
    // Pins toward the processor
    output logic ready_in,
    output logic hold_req_in
);
    int cnt = 0;

    initial
    begin
        ready_in = 1'h1;
        hold_req_in = 1'h0;
    end

    // Slow mode pulls ready low for five cycles from each taken request
    always @(posedge sys_clk)
    begin
        #2;
        if (req_taken === 1'h1 && slow)
            cnt = 5;
        else if (cnt != 0)
            cnt--;
        ready_in = (cnt == 0);
        hold_req_in = hold_on;
    end
endmodule
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the processor control and strobe block
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end

module tb_top;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic sys_clk = 1'h0;
    logic reset_n = 1'h0;
    logic cpu_reset_in = 1'h0;
    logic mode_select_in = 1'h1;
    logic maskable_irq_in = 1'h0;
    logic nmi_in = 1'h0;
    logic test_in_n = 1'h1;
    logic req_valid = 1'h0;
    cpu_ctrl_pkg::bus_req_t req = 3'h7;
    logic boundary = 1'h0;
    logic int_enable = 1'h0;
    logic wait_test = 1'h0;
    logic slow = 1'h0;
    logic hold_on = 1'h0;
    logic ready_in;
    logic hold_req_in;
    logic req_taken;
    logic cycle_done;
    logic restart;
    logic hold_grant_out;
    cpu_ctrl_pkg::irq_events_t events;
    cpu_ctrl_pkg::min_strobes_t min_pins;
    cpu_ctrl_pkg::max_status_t max_pins;
    int mismatches = 0;
    int n_checks = 0;
    logic [7:0] notes[$];
    logic [7:0] rnd = 8'h0b;
    logic [7:0] nt;
    logic io0;
    logic chg;
    logic bad_oe;
    logic wr;
    logic ak;
    int span = 0;
    int w_cnt = 0;
    int a_cnt = 0;

    always #12.5 sys_clk = ~sys_clk;

    cpu_control_inputs_min_mode_strobes u_dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .cpu_reset_in(cpu_reset_in),
        .mode_select_in(mode_select_in), .maskable_irq_in(maskable_irq_in), .nmi_in(nmi_in),
        .test_in_n(test_in_n), .ready_in(ready_in), .hold_req_in(hold_req_in),
        .req_valid(req_valid), .req(req), .boundary(boundary), .int_enable(int_enable),
        .wait_test(wait_test), .req_taken(req_taken), .cycle_done(cycle_done),
        .restart(restart), .events(events), .min_pins(min_pins), .max_pins(max_pins),
        .hold_grant_out(hold_grant_out)
    );

    bus_partner_model u_partner (
        .sys_clk(sys_clk), .req_taken(req_taken), .slow(slow), .hold_on(hold_on),
        .ready_in(ready_in), .hold_req_in(hold_req_in)
    );

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask

    task automatic pulse();
        boundary = 1'h1;
        tick(1);
        boundary = 1'h0;
    endtask

    task automatic pop_note(output logic [7:0] n);
        n = 8'hff;
        if (notes.size() != 0)
            n = notes.pop_front();
    endtask

    task automatic wait_taken();
        int i;
        i = 0;
        do
        begin
            tick(1);
            i++;
        end
        while (req_taken !== 1'h1 && i < 40);
        `CHK("req taken", 1'h1, req_taken)
        req_valid = 1'h0;
    endtask

    task automatic do_cycle(input cpu_ctrl_pkg::cycle_kind_t k, input logic s, input logic nte);
        tick(1);
        if (nte)
            notes.push_back({3'h1, s, 1'h0, k});
        slow = s;
        req.kind = k;
        req_valid = 1'h1;
        wait_taken();
        if (!mode_select_in)
            `CHK("max status", {k, 1'h1}, max_pins)
    endtask

    task automatic give_verdict();
        if (mismatches == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ----------------------------------------
    // Monitor: strobes per cycle and event pulses
    // ----------------------------------------
    always @(negedge sys_clk)
    begin
        if (req_taken !== 1'h1 && cycle_done !== 1'h1)
        begin
            span++;
            w_cnt += (min_pins.write_n === 1'h0);
            a_cnt += (min_pins.irq_ack_strobe_n === 1'h0);
            chg = chg | (min_pins.io_mem !== io0);
            bad_oe = bad_oe | (min_pins.io_mem_oe !== 1'h1);
        end
        if (cycle_done === 1'h1 && mode_select_in)
        begin
            pop_note(nt);
            wr = (nt[2:0] == cpu_ctrl_pkg::CYC_IO_WRITE) || (nt[2:0] == cpu_ctrl_pkg::CYC_MEM_WRITE);
            ak = (nt[2:0] == cpu_ctrl_pkg::CYC_INT_ACK);
            `CHK("cycle", {3'h1, ~nt[2], 2'h0, 2'h3, nt[4]}, {nt[7:5], io0, chg, bad_oe, w_cnt == (wr ? span - 1 : 0), a_cnt == (ak ? span - 1 : 0), span > 3})
        end
        if (events.nmi_take === 1'h1)
        begin
            pop_note(nt);
            `CHK("nmi take", 3'h3, nt[7:5])
        end
        if (events.irq_take === 1'h1)
        begin
            pop_note(nt);
            `CHK("irq take", 3'h2, nt[7:5])
        end
        if (restart === 1'h1)
        begin
            pop_note(nt);
            `CHK("restart", 3'h4, nt[7:5])
        end
        if (req_taken === 1'h1)
        begin
            span = 0;
            w_cnt = 0;
            a_cnt = 0;
            chg = 1'h0;
            bad_oe = 1'h0;
            io0 = min_pins.io_mem;
        end
    end

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    initial
    begin
        #150000;
        mismatches++;
        give_verdict();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        tick(5);
        reset_n = 1'h1;
        tick(6);
        // Every cycle kind but passive, then random kinds and speeds, back to back
        for (int k = 0; k < 7; k++)
            do_cycle(cpu_ctrl_pkg::cycle_kind_t'(k[2:0]), k[0], 1'h1);
        for (int j = 0; j < 12; j++)
        begin
            rnd = lfsr(rnd);
            do_cycle(cpu_ctrl_pkg::cycle_kind_t'(rnd[2:0] == 3'h7 ? 3'h6 : rnd[2:0]), rnd[3], 1'h1);
        end
        // Hold grant floats the strobes and refuses requests
        tick(8);
        hold_on = 1'h1;
        tick(5);
        `CHK("hold grant", 1'h1, hold_grant_out)
        `CHK("float", 5'h14, {min_pins.io_mem, min_pins.io_mem_oe, min_pins.write_n, min_pins.write_oe, min_pins.irq_ack_oe})
        slow = 1'h0;
        notes.push_back({3'h1, 2'h0, cpu_ctrl_pkg::CYC_MEM_WRITE});
        req.kind = cpu_ctrl_pkg::CYC_MEM_WRITE;
        req_valid = 1'h1;
        tick(6);
        `CHK("refused", 1'h0, req_taken)
        hold_on = 1'h0;
        wait_taken();
        // Maximum mode shows the status code instead
        tick(8);
        mode_select_in = 1'h0;
        tick(3);
        do_cycle(cpu_ctrl_pkg::CYC_MEM_READ, 1'h0, 1'h0);
        tick(8);
        mode_select_in = 1'h1;
        // Processor reset abandons a write, long pulse restarts, short one does not
        do_cycle(cpu_ctrl_pkg::CYC_MEM_WRITE, 1'h0, 1'h0);
        cpu_reset_in = 1'h1;
        tick(4);
        `CHK("abandon", 2'h2, {min_pins.write_n, cycle_done})
        tick(2);
        notes.push_back({3'h4, 5'h0});
        cpu_reset_in = 1'h0;
        tick(8);
        cpu_reset_in = 1'h1;
        tick(2);
        cpu_reset_in = 1'h0;
        tick(8);
        // Maskable request masked, nonmaskable taken regardless, then unmasked
        maskable_irq_in = 1'h1;
        tick(4);
        pulse();
        tick(3);
        nmi_in = 1'h1;
        notes.push_back({3'h3, 5'h0});
        tick(4);
        pulse();
        tick(3);
        int_enable = 1'h1;
        notes.push_back({3'h2, 5'h0});
        pulse();
        tick(3);
        maskable_irq_in = 1'h0;
        nmi_in = 1'h0;
        tick(4);
        pulse();
        tick(3);
        // Wait for test idles until test is asserted
        wait_test = 1'h1;
        tick(4);
        `CHK("test idle", 2'h1, {events.test_go, events.test_idle})
        test_in_n = 1'h0;
        tick(4);
        `CHK("test go", 2'h2, {events.test_go, events.test_idle})
        tick(10);
        `CHK("notes left", 0, notes.size())
        give_verdict();
    end
endmodule
`default_nettype wire
